// ===== logic/iec_top.v
// interrupt controller with eight single transfer service channels
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "iec_regs.vh"
module iec_top (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] periph_req,
  input wire [7:0] alt_req,
  input wire [3:0] ext_pin,
  input wire jump_cache,
  input wire [3:0] cpu_level,
  input wire int_ack,
  input wire steal_grant,
  output reg int_req,
  output reg [15:0] int_vector,
  output reg [3:0] int_level,
  output reg steal_req,
  output reg move_valid,
  output reg [23:0] move_src,
  output reg [23:0] move_dst,
  output reg move_word,
  output reg irq
);
  reg [3:0] n_lvl [0:15];
  reg [2:0] n_ch [0:15];
  reg [15:0] n_xfer;
  reg [15:0] n_en;
  reg [15:0] n_req;
  reg [23:0] c_src [0:7];
  reg [23:0] c_dst [0:7];
  reg [7:0] c_cnt [0:7];
  reg [3:0] c_ctl [0:7];
  reg [7:0] status;
  reg [7:0] mask;
  reg [7:0] edge_cfg;
  reg trap_pend;
  reg [7:0] trap_num;
  reg [1:0] state;
  reg [3:0] sel_node;
  reg sel_trap;
  reg [3:0] wait_cnt;
  reg [15:0] accept_clr;
  reg zero_set;
  reg trap_clr;
  reg [7:0] done_set;
  reg [31:0] next_rdata;
  reg next_err;

  wire [3:0] ext_pulse;
  wire [63:0] lvl_flat;
  wire arb_found;
  wire [3:0] arb_idx;
  wire [3:0] arb_lvl;

  function is_node;
    input [11:0] a;
    begin
      is_node = (a[11:6] == `IEC_A_NODE >> 6) && (a[1:0] == 2'b00);
    end
  endfunction

  function is_chan;
    input [11:0] a;
    begin
      is_chan = (a[11:7] == `IEC_A_CHAN >> 7) && (a[1:0] == 2'b00);
    end
  endfunction

  // node vector: trap number times four
  function [15:0] node_vec;
    input [7:0] num;
    begin
      node_vec = {6'h00, num, 2'b00};
    end
  endfunction

  wire wr = psel & penable & pready & pwrite;
  wire wr_status = wr && paddr == `IEC_A_STATUS;
  wire wr_trap = wr && paddr == `IEC_A_TRAP;
  wire [2:0] acc_ch = paddr[6:4];
  wire [2:0] sel_ch = n_ch[sel_node];
  wire [3:0] sel_ctl = c_ctl[sel_ch];
  wire sel_step = sel_ctl[`IEC_C_WORD] ? 1'b1 : 1'b0;
  wire [23:0] sel_inc = sel_ctl[`IEC_C_WORD] ? 24'h000002 : 24'h000001;
  wire [3:0] resp_clk = jump_cache ? `IEC_RESP_JC_CLK : `IEC_RESP_NOJC_CLK;
  // a node stays on the transfer path only while its channel has work left
  wire arb_xfer = n_xfer[arb_idx] &&
                  (c_ctl[n_ch[arb_idx]][`IEC_C_CONT] || c_cnt[n_ch[arb_idx]] != 8'h00);
  // second source bits placed on the shared node positions
  wire [15:0] alt_map = {2'b00, alt_req, 6'h00};
  wire [15:0] ext_map = {12'h000, ext_pulse};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : fast_in
      iec_edge u_edge (
        .clk(clk),
        .reset(reset),
        .pin(ext_pin[g]),
        .cfg(edge_cfg[g*2 +: 2]),
        .pulse(ext_pulse[g])
      );
    end
  endgenerate

  generate
    for (g = 0; g < `IEC_NODES; g = g + 1) begin : node
      wire wr_here = wr && is_node(paddr) && paddr[5:2] == g;
      // compare source, shared second source, fast input pulse or counter zero
      wire hw_set = periph_req[g] | alt_map[g] | ext_map[g] |
                    (zero_set && sel_node == g);
      assign lvl_flat[g*4 +: 4] = n_lvl[g];
      always @(posedge clk) begin
        if (reset) begin
          n_lvl[g] <= 4'h0;
          n_ch[g] <= 3'h0;
          n_xfer[g] <= 1'b0;
          n_en[g] <= 1'b0;
          n_req[g] <= 1'b0;
        end else begin
          if (wr_here) begin
            n_lvl[g] <= pwdata[`IEC_N_LVL_LO +: 4];
            n_ch[g] <= pwdata[`IEC_N_CH_LO +: 3];
            n_xfer[g] <= pwdata[`IEC_N_XFER];
            n_en[g] <= pwdata[`IEC_N_EN];
          end
          // software write of the request bit, cleared on accept
          // hardware set wins over both so that no event is dropped
          if (wr_here)
            n_req[g] <= pwdata[`IEC_N_REQ] | hw_set;
          else
            n_req[g] <= (n_req[g] & ~accept_clr[g]) | hw_set;
        end
      end
    end
  endgenerate

  generate
    for (g = 0; g < `IEC_CHANS; g = g + 1) begin : chan
      wire wr_here = wr && is_chan(paddr) && acc_ch == g;
      wire moving = state == `IEC_ST_STEAL && steal_grant && sel_ch == g;
      always @(posedge clk) begin
        if (reset) begin
          c_src[g] <= 24'h000000;
          c_dst[g] <= 24'h000000;
          c_cnt[g] <= 8'h00;
          c_ctl[g] <= 4'h0;
        end else if (moving) begin
          // step pointers by the moved size
          if (c_ctl[g][`IEC_C_INCS])
            c_src[g] <= c_src[g] + sel_inc;
          if (c_ctl[g][`IEC_C_INCD])
            c_dst[g] <= c_dst[g] + sel_inc;
          if (!c_ctl[g][`IEC_C_CONT])
            c_cnt[g] <= c_cnt[g] - 8'h01;
        end else if (wr_here) begin
          case (paddr[3:2])
            `IEC_CH_SRC: c_src[g] <= pwdata[23:0];
            `IEC_CH_DST: c_dst[g] <= pwdata[23:0];
            `IEC_CH_CNT: c_cnt[g] <= pwdata[7:0];
            default: c_ctl[g] <= pwdata[3:0];
          endcase
        end
      end
    end
  endgenerate

  iec_arb u_arb (
    .req(n_req),
    .en(n_en),
    .lvl_flat(lvl_flat),
    .floor(cpu_level),
    .found(arb_found),
    .idx(arb_idx),
    .lvl(arb_lvl)
  );

  // events, accept pulses and counter-zero detection for the service sequencer
  always @* begin
    accept_clr = 16'h0000;
    zero_set = 1'b0;
    trap_clr = 1'b0;
    done_set = 8'h00;
    if (state == `IEC_ST_OFFER && int_ack) begin
      if (sel_trap)
        trap_clr = 1'b1;
      else
        accept_clr[sel_node] = 1'b1;
    end
    if (state == `IEC_ST_STEAL && steal_grant) begin
      accept_clr[sel_node] = 1'b1;
      // last transfer re-raises the node as a standard interrupt
      if (!sel_ctl[`IEC_C_CONT] && c_cnt[sel_ch] == 8'h01) begin
        zero_set = 1'b1;
        done_set[sel_ch] = 1'b1;
      end
    end
  end

  // service sequencer
  always @(posedge clk) begin
    if (reset) begin
      state <= `IEC_ST_IDLE;
      sel_node <= 4'h0;
      sel_trap <= 1'b0;
      wait_cnt <= 4'h0;
      int_req <= 1'b0;
      int_vector <= 16'h0000;
      int_level <= 4'h0;
      steal_req <= 1'b0;
      move_valid <= 1'b0;
      move_src <= 24'h000000;
      move_dst <= 24'h000000;
      move_word <= 1'b0;
    end else begin
      move_valid <= 1'b0;
      case (state)
        `IEC_ST_IDLE: begin
          // a pending trap goes first, it has no level to arbitrate
          if (trap_pend) begin
            sel_trap <= 1'b1;
            int_vector <= node_vec(trap_num);
            int_level <= 4'hF;
            wait_cnt <= resp_clk;
            state <= `IEC_ST_WAIT;
          end else if (arb_found) begin
            sel_trap <= 1'b0;
            sel_node <= arb_idx;
            // per node choice of service path
            if (arb_xfer) begin
              steal_req <= 1'b1;
              state <= `IEC_ST_STEAL;
            end else begin
              int_vector <= node_vec(`IEC_TRAP_BASE + {4'h0, arb_idx});
              int_level <= arb_lvl;
              wait_cnt <= resp_clk;
              state <= `IEC_ST_WAIT;
            end
          end
        end
        `IEC_ST_WAIT: begin
          // fixed response latency before the core sees the request
          wait_cnt <= wait_cnt - 4'h1;
          if (!sel_trap && !(n_req[sel_node] && n_en[sel_node])) begin
            state <= `IEC_ST_IDLE;
          end else if (wait_cnt == 4'h1) begin
            int_req <= 1'b1;
            state <= `IEC_ST_OFFER;
          end
        end
        `IEC_ST_OFFER: begin
          // offer held until the core takes the vector or the node's request or enable drops
          if (int_ack) begin
            int_req <= 1'b0;
            state <= `IEC_ST_IDLE;
          end else if (!sel_trap && !(n_req[sel_node] && n_en[sel_node])) begin
            int_req <= 1'b0;
            state <= `IEC_ST_IDLE;
          end
        end
        `IEC_ST_STEAL: begin
          // one stolen cycle, one move pulse, no vector
          if (steal_grant) begin
            steal_req <= 1'b0;
            move_valid <= 1'b1;
            move_src <= c_src[sel_ch];
            move_dst <= c_dst[sel_ch];
            move_word <= sel_step;
            state <= `IEC_ST_IDLE;
          end
        end
        default: begin
          state <= `IEC_ST_IDLE;
        end
      endcase
    end
  end

  // status, mask, trap and edge registers
  always @(posedge clk) begin
    if (reset) begin
      status <= 8'h00;
      mask <= 8'h00;
      edge_cfg <= 8'h00;
      trap_pend <= 1'b0;
      trap_num <= 8'h00;
      irq <= 1'b0;
    end else begin
      // write one to clear, a completion in the same cycle still sticks
      status <= (status & ~(wr_status ? pwdata[7:0] : 8'h00)) | done_set;
      if (wr && paddr == `IEC_A_MASK)
        mask <= pwdata[7:0];
      if (wr && paddr == `IEC_A_EDGE)
        edge_cfg <= pwdata[7:0];
      if (wr_trap)
        trap_num <= pwdata[7:0];
      trap_pend <= wr_trap | (trap_pend & ~trap_clr);
      irq <= |(status & mask);
    end
  end

  // apb read decode
  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    if (is_node(paddr)) begin
      next_rdata[`IEC_N_LVL_LO +: 4] = n_lvl[paddr[5:2]];
      next_rdata[`IEC_N_CH_LO +: 3] = n_ch[paddr[5:2]];
      next_rdata[`IEC_N_XFER] = n_xfer[paddr[5:2]];
      next_rdata[`IEC_N_EN] = n_en[paddr[5:2]];
      next_rdata[`IEC_N_REQ] = n_req[paddr[5:2]];
    end else if (is_chan(paddr)) begin
      case (paddr[3:2])
        `IEC_CH_SRC: next_rdata[23:0] = c_src[acc_ch];
        `IEC_CH_DST: next_rdata[23:0] = c_dst[acc_ch];
        `IEC_CH_CNT: next_rdata[7:0] = c_cnt[acc_ch];
        default: next_rdata[3:0] = c_ctl[acc_ch];
      endcase
    end else begin
      case (paddr)
        `IEC_A_STATUS: next_rdata[7:0] = status;
        `IEC_A_MASK: next_rdata[7:0] = mask;
        `IEC_A_TRAP: next_rdata[8:0] = {trap_pend, trap_num};
        `IEC_A_EDGE: next_rdata[7:0] = edge_cfg;
        `IEC_A_STATE: next_rdata[6:0] = {sel_trap, sel_node, state};
        default: next_err = 1'b1;
      endcase
    end
  end

  // no wait state: pready answers in the first access cycle
  always @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h00000000;
      pslverr <= psel & ~penable & next_err;
    end
  end
endmodule

// ===== logic/iec_regs.vh
// constants for the interrupt and event transfer controller
//
// Behaviour
// - a granted interrupt is offered 7 clocks later with jump cache, else 11
// - each node is set to vectored interrupt or single transfer service
// - a standard service is offered to the core with the node vector
// - a transfer service steals exactly one core cycle, no vector
// - a transfer moves one byte or word, then steps source and/or destination
// - the channel counter drops by one per transfer, not in continuous mode
// - a counter reaching zero raises a standard interrupt on the source node
// - eight channels, each with source pointer, destination pointer and counter
// - each node has a control register with request, enable and level
// - levels 1 to 15 arbitrate among pending requests, level 0 is never granted
// - a request is granted only when its level beats the running level
// - each node has its own vector location
// - fast external inputs detect rising, falling or both edges
// - a software trap number raises an interrupt to that number's vector
// - software setting a request bit raises a request like hardware
// - vector offset is trap number times four, node 0 is trap 10h
// - nodes 16h to 1Dh take a second request source as well
`ifndef IEC_REGS_VH
`define IEC_REGS_VH

`define IEC_NODES 16
`define IEC_CHANS 8
`define IEC_TRAP_BASE 8'h10
`define IEC_SHARED_LO 6
`define IEC_SHARED_HI 13

`define IEC_CLK_MHZ 25
`define IEC_RESP_JC_CLK 4'd7
`define IEC_RESP_NOJC_CLK 4'd11

`define IEC_A_NODE 12'h000
`define IEC_A_CHAN 12'h080
`define IEC_A_STATUS 12'h100
`define IEC_A_MASK 12'h104
`define IEC_A_TRAP 12'h108
`define IEC_A_EDGE 12'h10C
`define IEC_A_STATE 12'h110

`define IEC_CH_SRC 2'h0
`define IEC_CH_DST 2'h1
`define IEC_CH_CNT 2'h2
`define IEC_CH_CTL 2'h3

`define IEC_N_LVL_LO 0
`define IEC_N_CH_LO 4
`define IEC_N_XFER 7
`define IEC_N_EN 8
`define IEC_N_REQ 9

`define IEC_C_WORD 0
`define IEC_C_INCS 1
`define IEC_C_INCD 2
`define IEC_C_CONT 3

`define IEC_ST_IDLE 2'h0
`define IEC_ST_WAIT 2'h1
`define IEC_ST_OFFER 2'h2
`define IEC_ST_STEAL 2'h3

`endif

// ===== logic/iec_edge.v
// fast external input: synchroniser and programmable edge detector
`include "iec_regs.vh"
module iec_edge (
  input wire clk,
  input wire reset,
  input wire pin,
  input wire [1:0] cfg,
  output reg pulse
);
  reg sync_a;
  reg sync_b;
  reg prev;
  always @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev <= sync_b;
      pulse <= (cfg[0] & sync_b & ~prev) | (cfg[1] & ~sync_b & prev);
    end
  end
endmodule

// ===== logic/iec_arb.v
// priority search over the interrupt nodes
`include "iec_regs.vh"
module iec_arb (
  input wire [15:0] req,
  input wire [15:0] en,
  input wire [63:0] lvl_flat,
  input wire [3:0] floor,
  output reg found,
  output reg [3:0] idx,
  output reg [3:0] lvl
);
  integer i;
  always @* begin
    found = 1'b0;
    idx = 4'h0;
    lvl = 4'h0;
    for (i = 0; i < `IEC_NODES; i = i + 1) begin
      // eligible nodes, strict compare keeps the lower index on a tie
      // level must beat the running level and the best so far
      if (req[i] && en[i] && lvl_flat[i*4 +: 4] > floor &&
          (!found || lvl_flat[i*4 +: 4] > lvl)) begin
        found = 1'b1;
        idx = i[3:0];
        lvl = lvl_flat[i*4 +: 4];
      end
    end
  end
endmodule

// ===== verif/iec_checker.sv
// port-level checks for the interrupt and transfer controller
module iec_checker (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire [3:0] cpu_level,
  input wire int_ack,
  input wire steal_grant,
  input wire int_req,
  input wire [15:0] int_vector,
  input wire [3:0] int_level,
  input wire steal_req,
  input wire move_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence grant_s;
    steal_req && steal_grant;
  endsequence
  sequence one_move_s;
    move_valid ##1 !move_valid;
  endsequence
  // a bus write withdraws an offer one cycle after it lands, so only quiet cycles are judged
  offer_hold_a: assert property (
    int_req && !int_ack && !psel && !$past(psel) |=> int_req && $stable(int_vector))
    else $error("offer dropped early");
  ack_drop_a: assert property (int_req && int_ack |=> !int_req)
    else $error("offer kept after ack");
  vector_align_a: assert property (int_req |-> int_vector[1:0] == 2'h0)
    else $error("vector not word aligned");
  level_above_a: assert property ($rose(int_req) |-> int_level > cpu_level)
    else $error("offer not above running level");
  level_live_a: assert property (int_req |-> int_level != 4'h0)
    else $error("offer at level zero");
  steal_hold_a: assert property (steal_req && !steal_grant |=> steal_req)
    else $error("steal request dropped");
  grant_move_a: assert property (grant_s |=> one_move_s)
    else $error("grant without single move");
  move_cause_a: assert property ($rose(move_valid) |-> $past(steal_req && steal_grant))
    else $error("move without grant");
endmodule

// ===== verif/iec_core_model.sv
// core stand-in: acknowledges offers and grants stolen cycles after a delay
module iec_core_model (
  input wire clk,
  input wire reset,
  input wire [3:0] delay,
  input wire int_req,
  input wire steal_req,
  output logic int_ack,
  output logic steal_grant
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ack_cnt, grant_cnt;
  // answers last one cycle only, so a block that holds its request is caught
  always @(posedge clk) begin
    int_ack <= 1'b0;
    steal_grant <= 1'b0;
    ack_cnt <= 4'h0;
    grant_cnt <= 4'h0;
    if (!reset && int_req && !int_ack) begin
      ack_cnt <= ack_cnt + 4'h1;
      int_ack <= ack_cnt == delay;
    end
    if (!reset && steal_req && !steal_grant) begin
      grant_cnt <= grant_cnt + 4'h1;
      steal_grant <= grant_cnt == delay;
    end
  end
endmodule

// ===== verif/interrupt_and_event_transfer_tb.sv
// self-checking bench for the interrupt and transfer controller
module interrupt_and_event_transfer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, psel, penable, pwrite, jump_cache, err, pready, pslverr, irq;
  logic int_ack, steal_grant, int_req, steal_req, move_valid, move_word;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] periph_req, int_vector;
  logic [7:0] alt_req;
  logic [3:0] ext_pin, cpu_level, int_level, delay;
  logic [23:0] move_src, move_dst;
  int fails = 0;
  int compares = 0;

  iec_top iec_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .alt_req(alt_req), .ext_pin(ext_pin),
    .jump_cache(jump_cache), .cpu_level(cpu_level), .int_ack(int_ack),
    .steal_grant(steal_grant), .int_req(int_req), .int_vector(int_vector),
    .int_level(int_level), .steal_req(steal_req), .move_valid(move_valid),
    .move_src(move_src), .move_dst(move_dst), .move_word(move_word), .irq(irq));
  iec_core_model iec_core_model_inst (.clk(clk), .reset(reset), .delay(delay),
    .int_req(int_req), .steal_req(steal_req), .int_ack(int_ack),
    .steal_grant(steal_grant));

  always #20 clk = ~clk;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rdat);
  endtask

  task automatic pulse(input logic [15:0] p, input logic [7:0] a);
    periph_req <= p;
    alt_req <= a;
    @(posedge clk);
    periph_req <= 16'h0;
    alt_req <= 8'h0;
  endtask

  task automatic offer(input logic [15:0] v, input logic [3:0] l, input logic y);
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("offer", 32'(y), 32'(int_req));
    if (y) chk("vector", 32'(v), 32'(int_vector));
    if (y) chk("level", 32'(l), 32'(int_level));
    while (int_req === 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask

  task automatic move(input logic [23:0] s, input logic [23:0] d, input logic w);
    int n;
    n = 0;
    while (move_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("source", 32'(s), 32'(move_src));
    chk("dest", 32'(d), 32'(move_dst));
    chk("width", 32'(w), 32'(move_word));
    @(posedge clk);
  endtask

  task automatic t_regs;
    rd(12'h03C, 32'h0);
    wr(12'h03C, 32'h07F);
    rd(12'h03C, 32'h07F);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("slave error", 32'h1, 32'(err));
  endtask

  task automatic t_lat(input logic j);
    int n;
    n = 0;
    jump_cache <= j;
    wr(12'h014, 32'h105);
    pulse(16'h0020, 8'h0);
    // one edge sets the flag, one arbitrates, then the response time
    do begin
      @(negedge clk);
      n++;
    end while (int_req !== 1'b1 && n < 40);
    chk("latency", j ? 32'd9 : 32'd13, 32'(n));
    offer(16'h0054, 4'h5, 1'b1);
    rd(12'h014, 32'h105);
  endtask

  task automatic t_prio;
    cpu_level <= 4'hF;
    wr(12'h008, 32'h304);
    wr(12'h024, 32'h306);
    wr(12'h004, 32'h306);
    cpu_level <= 4'h5;
    offer(16'h0044, 4'h6, 1'b1);
    offer(16'h0064, 4'h6, 1'b1);
    offer(16'h0, 4'h0, 1'b0);
    cpu_level <= 4'h0;
    offer(16'h0048, 4'h4, 1'b1);
  endtask

  task automatic t_edge;
    logic [1:0] m;
    wr(12'h000, 32'h101);
    for (m = 2'h1; m != 2'h0; m++) begin
      wr(12'h10C, 32'(m));
      ext_pin <= 4'h1;
      offer(16'h0040, 4'h1, m[0]);
      ext_pin <= 4'h0;
      offer(16'h0040, 4'h1, m[1]);
    end
  endtask

  task automatic t_alt;
    wr(12'h020, 32'h101);
    pulse(16'h0, 8'h04);
    offer(16'h0060, 4'h1, 1'b1);
    wr(12'h108, 32'h02A);
    offer(16'h00A8, 4'hF, 1'b1);
  endtask

  // a slow core lets software disable the offered node before the acknowledge
  task automatic t_cut;
    delay <= 4'hF;
    wr(12'h028, 32'h305);
    while (int_req !== 1'b1) @(negedge clk);
    @(posedge clk);
    wr(12'h028, 32'h005);
    @(negedge clk);
    chk("withdrawn", 32'h0, 32'(int_req));
    @(posedge clk);
    rd(12'h110, 32'h28);
  endtask

  task automatic t_pec;
    delay <= 4'h3;
    wr(12'h0F0, 32'h1000);
    wr(12'h0F4, 32'h2000);
    wr(12'h0F8, 32'h2);
    wr(12'h0FC, 32'h7);
    wr(12'h104, 32'h80);
    wr(12'h010, 32'h1F2);
    pulse(16'h0010, 8'h0);
    move(24'h001000, 24'h002000, 1'b1);
    offer(16'h0, 4'h0, 1'b0);
    pulse(16'h0010, 8'h0);
    move(24'h001002, 24'h002002, 1'b1);
    offer(16'h0050, 4'h2, 1'b1);
    chk("irq", 32'h1, 32'(irq));
    wr(12'h100, 32'h80);
    rd(12'h0F8, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    wr(12'h080, 32'h3000);
    wr(12'h084, 32'h4000);
    wr(12'h088, 32'h5);
    wr(12'h08C, 32'hA);
    wr(12'h00C, 32'h182);
    pulse(16'h0008, 8'h0);
    move(24'h003000, 24'h004000, 1'b0);
    rd(12'h080, 32'h3001);
    rd(12'h084, 32'h4000);
    rd(12'h088, 32'h5);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {periph_req, alt_req, ext_pin, cpu_level} = '0;
    jump_cache = 1'b1;
    delay = 4'h1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_regs;
    t_lat(1'b1);
    t_lat(1'b0);
    t_prio;
    t_edge;
    t_alt;
    t_cut;
    t_pec;
    report_and_stop;
  end

  // the whole run needs a few hundred cycles
  initial begin
    #400000;
    fails++;
    report_and_stop;
  end
endmodule

bind iec_top iec_checker iec_checker_inst (.clk(clk), .reset(reset), .psel(psel),
  .cpu_level(cpu_level), .int_ack(int_ack), .steal_grant(steal_grant),
  .int_req(int_req), .int_vector(int_vector), .int_level(int_level),
  .steal_req(steal_req), .move_valid(move_valid));
